/* File: logic/registered_bus_transceiver_scan.sv */
// Purpose: Two 9-bit registered bus transceivers with a four-wire scan test port.
// Assumes: All pins are asynchronous to CLK and far slower than it; TCK below CLK/4.
// Notes:   Pin paths see three cycles of latency from synchroniser and output flop.
`timescale 1ns/1ns

// How it works
// - High latch enable passes A straight to B.
// - Latch low, clock steady: hold stored value.
// - Latch low: store A on clock rise.
// - Low enable drives B, high floats B.
// - B-to-A path mirrors A-to-B path.
// - Two 9-bit halves, usable as 18-bit.
// - Test mode: scan logic owns all pins.
// - Scan in normal mode leaves datapath alone.
// - Sample on TCK rise, outputs on fall, except pattern and count outputs, which step on rise.
// - TDI feeds shifted register; idles high.
// - TDO shows shifted register's serial output.
// - TMS steers the TAP; idles high.
// - Two scan cells per bit, A and B.
// - Signature on inputs, or random pattern on B outputs.
// - Count on outputs while compressing inputs.
// - Test functions sequenced only by TAP.
// - TAP reset state disables test logic.
// - Five TCKs with TMS high reach reset.
module registered_bus_transceiver_scan
    import bus_xcvr_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    // A bus pins
    input  wire logic [BUS_W-1:0]  A_IN,
    output logic      [BUS_W-1:0]  A_OUT,
    output logic      [BUS_W-1:0]  A_OE,
    // B bus pins
    input  wire logic [BUS_W-1:0]  B_IN,
    output logic      [BUS_W-1:0]  B_OUT,
    output logic      [BUS_W-1:0]  B_OE,
    // Per-half direction controls
    input  wire logic [HALVES-1:0] A_TO_B_OUTPUT_ENABLE_N,
    input  wire logic [HALVES-1:0] B_TO_A_OUTPUT_ENABLE_N,
    input  wire logic [HALVES-1:0] A_TO_B_LATCH_ENABLE,
    input  wire logic [HALVES-1:0] B_TO_A_LATCH_ENABLE,
    input  wire logic [HALVES-1:0] A_TO_B_CLOCK,
    input  wire logic [HALVES-1:0] B_TO_A_CLOCK,
    // Test access port
    input  wire logic              TCK,
    input  wire logic              TMS,
    input  wire logic              TDI,
    output logic                   TDO,
    output logic                   TDO_OE
);
    logic [BUS_W-1:0]  a_s1, a_s, b_s1, b_s;
    logic [11:0]       ctl_s1, ctl_s;
    logic [2:0]        tap_s1, tap_s;
    logic              tck_d;
    logic [HALVES-1:0] ab_clk_d, ba_clk_d;
    logic [HALVES-1:0] ab_oe_n, ba_oe_n, ab_le, ba_le, ab_clk, ba_clk, ab_rise, ba_rise;
    logic              tck_s, tms_s, tdi_s, tck_rise, tck_fall;
    logic [BUS_W-1:0]  ab_store, ba_store, ab_norm, ba_norm;
    tap_state_t        tap_state, next_tap_state;
    logic [IR_W-1:0]   ir, ir_sh;
    logic [BSR_W-1:0]  bsr, bsu;
    logic              byp;
    logic [BUS_W-1:0]  sig, pat, cnt;
    logic              test_mode, compress_op, dr_lsb, push_fire, sig_busy;
    logic [BUS_W-1:0]  test_a, test_b, a_out, b_out, a_oe, b_oe;
    logic              tdo, tdo_oe;
    logic [2:0]        tms_hi_cnt;

    stream_if #(.W(BUS_W)) sample_in ();
    stream_if #(.W(BUS_W)) sample_out ();

    // Every input pin but CLK and RST_N passes two flops; only the second stage is read.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            a_s1   <= BUS_RST;
            a_s    <= BUS_RST;
            b_s1   <= BUS_RST;
            b_s    <= BUS_RST;
            ctl_s1 <= CTL_SYNC_RST;
            ctl_s  <= CTL_SYNC_RST;
            tap_s1 <= TAP_SYNC_RST;
            tap_s  <= TAP_SYNC_RST;
        end else begin
            a_s1   <= A_IN;
            a_s    <= a_s1;
            b_s1   <= B_IN;
            b_s    <= b_s1;
            ctl_s1 <= {A_TO_B_CLOCK, B_TO_A_CLOCK, A_TO_B_LATCH_ENABLE, B_TO_A_LATCH_ENABLE,
                       A_TO_B_OUTPUT_ENABLE_N, B_TO_A_OUTPUT_ENABLE_N};
            ctl_s  <= ctl_s1;
            tap_s1 <= {TCK, TMS, TDI};
            tap_s  <= tap_s1;
        end
    end

    assign {ab_clk, ba_clk, ab_le, ba_le, ab_oe_n, ba_oe_n} = ctl_s;
    assign {tck_s, tms_s, tdi_s} = tap_s;
    assign ab_rise  = ab_clk & ~ab_clk_d;
    assign ba_rise  = ba_clk & ~ba_clk_d;
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ab_clk_d <= '0;
            ba_clk_d <= '0;
            tck_d    <= 1'b0;
        end else begin
            ab_clk_d <= ab_clk;
            ba_clk_d <= ba_clk;
            tck_d    <= tck_s;
        end
    end

    // While the latch is open the store tracks the bus, so closing it keeps the last word.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ab_store <= BUS_RST;
            ba_store <= BUS_RST;
        end else begin
            for (int h = 0; h < HALVES; h++) begin
                if (ab_le[h] || ab_rise[h]) begin
                    ab_store[h*HALF_W +: HALF_W] <= a_s[h*HALF_W +: HALF_W];
                end
                if (ba_le[h] || ba_rise[h]) begin
                    ba_store[h*HALF_W +: HALF_W] <= b_s[h*HALF_W +: HALF_W];
                end
            end
        end
    end

    always_comb begin
        for (int h = 0; h < HALVES; h++) begin
            ab_norm[h*HALF_W +: HALF_W] = ab_le[h] ? a_s[h*HALF_W +: HALF_W]
                                                   : ab_store[h*HALF_W +: HALF_W];
            ba_norm[h*HALF_W +: HALF_W] = ba_le[h] ? b_s[h*HALF_W +: HALF_W]
                                                   : ba_store[h*HALF_W +: HALF_W];
        end
    end

    always_comb begin
        next_tap_state = tap_state;
        case (tap_state)
            TAP_RESET:    next_tap_state = tms_s ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     next_tap_state = tms_s ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   next_tap_state = tms_s ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   next_tap_state = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap_state = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap_state = tms_s ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap_state = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap_state = tms_s ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   next_tap_state = tms_s ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   next_tap_state = tms_s ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   next_tap_state = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap_state = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap_state = tms_s ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap_state = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap_state = tms_s ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   next_tap_state = tms_s ? TAP_SEL_DR   : TAP_IDLE;
            default:      next_tap_state = TAP_RESET;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tap_state <= TAP_RESET;
        end else if (tck_rise) begin
            tap_state <= next_tap_state;
        end
    end

    assign compress_op = (ir == OP_PSA) || (ir == OP_COUNT);
    // Only instructions that take the pins leave the normal datapath in charge otherwise.
    assign test_mode = (tap_state != TAP_RESET) &&
                       (ir == OP_EXTEST || ir == OP_PSEUDO_RANDOM_PATTERN_GEN || compress_op);

    // Shift and capture of instruction and data registers happen on TCK rise.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ir_sh <= IR_CAPTURE;
            bsr   <= BSR_RST;
            byp   <= 1'b0;
        end else if (tck_rise) begin
            case (tap_state)
                TAP_CAP_IR:   ir_sh <= IR_CAPTURE;
                TAP_SHIFT_IR: ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
                TAP_CAP_DR: begin
                    byp <= 1'b0;
                    bsr <= {~ba_oe_n, ~ab_oe_n, b_s, a_s};
                end
                TAP_SHIFT_DR: begin
                    byp <= tdi_s;
                    bsr <= {tdi_s, bsr[BSR_W-1:1]};
                end
                default: begin
                    byp <= byp;
                end
            endcase
        end
    end

    // Instruction and boundary update registers change on TCK fall.
    always_ff @(posedge CLK) begin
        if (!RST_N || tap_state == TAP_RESET) begin
            ir  <= OP_BYPASS;
            bsu <= BSR_RST;
        end else if (tck_fall) begin
            if (tap_state == TAP_UPD_IR) begin
                ir <= ir_sh;
            end
            if (tap_state == TAP_UPD_DR && (ir == OP_EXTEST || ir == OP_SAMPLE)) begin
                bsu <= bsr;
            end
        end
    end

    always_comb begin
        case (ir)
            OP_EXTEST, OP_SAMPLE:     dr_lsb = bsr[0];
            OP_PSA, OP_COUNT, OP_PSEUDO_RANDOM_PATTERN_GEN: dr_lsb = sig[0];
            default:                  dr_lsb = byp;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= (tap_state == TAP_SHIFT_IR) ? ir_sh[0] : dr_lsb;
            tdo_oe <= (tap_state == TAP_SHIFT_IR) || (tap_state == TAP_SHIFT_DR);
        end
    end

    // Pin words are sampled once per idle TCK; a full FIFO stalls the count so no address is skipped.
    assign sample_in.valid = tck_rise && tap_state == TAP_IDLE && compress_op;
    assign sample_in.data  = a_s;
    assign push_fire       = sample_in.valid && sample_in.ready;
    assign sig_busy        = (tap_state == TAP_CAP_DR) || (tap_state == TAP_SHIFT_DR);
    assign sample_out.ready = !sig_busy;

    word_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) sample_fifo (
        .CLK   (CLK),
        .RST_N (RST_N),
        .in_s  (sample_in),
        .out_s (sample_out)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N || tap_state == TAP_RESET) begin
            sig <= BUS_RST;
            pat <= PSEUDO_RANDOM_PATTERN_GEN_SEED;
            cnt <= BUS_RST;
        end else begin
            if (tck_rise && tap_state == TAP_SHIFT_DR && (compress_op || ir == OP_PSEUDO_RANDOM_PATTERN_GEN)) begin
                sig <= {tdi_s, sig[BUS_W-1:1]};
            end else if (sample_out.valid && sample_out.ready) begin
                sig <= {sig[BUS_W-2:0], sig[BUS_W-1] ^ sig[10]} ^ sample_out.data;
            end
            if (tck_rise && tap_state == TAP_IDLE && ir == OP_PSEUDO_RANDOM_PATTERN_GEN) begin
                pat <= {pat[BUS_W-2:0], pat[BUS_W-1] ^ pat[10]};
            end
            if (push_fire && ir == OP_COUNT) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    assign test_a = bsu[BSR_A_LSB +: BUS_W];
    assign test_b = (ir == OP_PSEUDO_RANDOM_PATTERN_GEN)  ? pat :
                    (ir == OP_COUNT) ? cnt : bsu[BSR_B_LSB +: BUS_W];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            a_out <= BUS_RST;
            b_out <= BUS_RST;
            a_oe  <= BUS_RST;
            b_oe  <= BUS_RST;
        end else if (test_mode) begin
            a_out <= test_a;
            b_out <= test_b;
            b_oe  <= {{HALF_W{bsu[BSR_OE_LSB+1]}}, {HALF_W{bsu[BSR_OE_LSB]}}};
            a_oe  <= {{HALF_W{bsu[BSR_OE_LSB+3]}}, {HALF_W{bsu[BSR_OE_LSB+2]}}};
        end else begin
            a_out <= ba_norm;
            b_out <= ab_norm;
            b_oe  <= {{HALF_W{~ab_oe_n[1]}}, {HALF_W{~ab_oe_n[0]}}};
            a_oe  <= {{HALF_W{~ba_oe_n[1]}}, {HALF_W{~ba_oe_n[0]}}};
        end
    end

    assign A_OUT  = a_out;
    assign B_OUT  = b_out;
    assign A_OE   = a_oe;
    assign B_OE   = b_oe;
    assign TDO    = tdo;
    assign TDO_OE = tdo_oe;

    // Run length of TMS-high TCK rises, for the reset-reach check.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tms_hi_cnt <= '0;
        end else if (tck_rise) begin
            tms_hi_cnt <= !tms_s ? '0 : (tms_hi_cnt == TMS_RUN_MAX) ? tms_hi_cnt : tms_hi_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_TRANSPARENT: assert property ((!test_mode && ab_le[0]) |=> b_out[8:0] == $past(a_s[8:0]))
        else $error("transparent A to B mismatch");
    AST_HOLD: assert property ((!ab_le[1] && !ab_rise[1]) |=> ab_store[17:9] == $past(ab_store[17:9]))
        else $error("stored half changed without clock");
    AST_CAPTURE: assert property ((!ab_le[0] && ab_rise[0]) |=> ab_store[8:0] == $past(a_s[8:0]))
        else $error("clock edge did not store A");
    AST_OE: assert property (!test_mode |=> b_oe[8:0] == {HALF_W{!$past(ab_oe_n[0])}})
        else $error("B enable does not follow control");
    AST_BA_PATH: assert property ((!test_mode && ba_le[1]) |=> a_out[17:9] == $past(b_s[17:9]))
        else $error("transparent B to A mismatch");
    AST_TEST_DRIVE: assert property ((test_mode && ir == OP_EXTEST) |=> a_out == $past(test_a))
        else $error("A pins not driven by scan");
    AST_SAMPLE_NORMAL: assert property ((ir == OP_SAMPLE) |=> b_out == $past(ab_norm))
        else $error("sampling took the pins");
    AST_TDO_FALL: assert property ($changed(tdo) |-> $past(tck_fall))
        else $error("TDO changed off a falling TCK");
    AST_IR_CAP: assert property ((tck_rise && tap_state == TAP_CAP_IR) |=> ir_sh == IR_CAPTURE)
        else $error("instruction capture value wrong");
    AST_COUNT_STALL: assert property ($changed(cnt) && tap_state != TAP_RESET |-> $past(push_fire))
        else $error("count moved without a sample");
    AST_TLR: assert property ((tap_state == TAP_RESET) |=> (ir == OP_BYPASS && !test_mode))
        else $error("test logic active in reset state");
    AST_FIVE: assert property ((tms_hi_cnt == TMS_RUN_MAX) |-> tap_state == TAP_RESET)
        else $error("five TMS-high clocks did not reset TAP");

    COV_TRANSPARENT: cover property (!test_mode && ab_le[0] ##1 ab_le[0]);
    COV_CLOCKED: cover property (!ab_le[1] && ab_rise[1]);
    COV_SHIFT_DR: cover property (tck_rise && tap_state == TAP_SHIFT_DR);
    COV_FIFO_FULL: cover property (sample_in.valid && !sample_in.ready);
endmodule : registered_bus_transceiver_scan

/* File: logic/bus_xcvr_pkg.sv */
// Purpose: Shared constants and types for the scan-testable bus transceiver.
// Assumes: One system clock; all input pins but CLK and RST_N are sampled through two flip-flops.
// Notes:   Opcodes have even parity and are local choices.
package bus_xcvr_pkg;
    localparam int HALF_W     = 9;
    localparam int HALVES     = 2;
    localparam int BUS_W      = HALF_W * HALVES;
    localparam int IR_W       = 8;
    localparam int OE_CELLS   = 4;
    localparam int BSR_W      = 2 * BUS_W + OE_CELLS;
    localparam int FIFO_DEPTH = 4;

    // Field positions inside the boundary register.
    localparam int BSR_A_LSB  = 0;
    localparam int BSR_B_LSB  = BUS_W;
    localparam int BSR_OE_LSB = 2 * BUS_W;

    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
    localparam logic [IR_W-1:0] OP_BYPASS  = 8'hFF;
    localparam logic [IR_W-1:0] OP_EXTEST  = 8'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 8'h82;
    localparam logic [IR_W-1:0] OP_PSA     = 8'h03;
    localparam logic [IR_W-1:0] OP_PSEUDO_RANDOM_PATTERN_GEN    = 8'h05;
    localparam logic [IR_W-1:0] OP_COUNT   = 8'h06;

    // Reset values and the TMS-high run limit.
    localparam logic [BUS_W-1:0] PSEUDO_RANDOM_PATTERN_GEN_SEED    = 18'h00001;
    localparam logic [BUS_W-1:0] BUS_RST      = 18'h00000;
    localparam logic [BSR_W-1:0] BSR_RST      = 40'h00_0000_0000;
    localparam logic [11:0]      CTL_SYNC_RST = 12'h00F;
    localparam logic [2:0]       TAP_SYNC_RST = 3'h3;
    localparam logic [2:0]       TMS_RUN_MAX  = 3'h5;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_t;
endpackage : bus_xcvr_pkg

/* File: logic/stream_if.sv */
// Purpose: Valid/ready word channel between the sampler, the FIFO and the compressor.
// Assumes: Both ends on CLK.
// Notes:   A word moves when valid and ready are both high.
`timescale 1ns/1ns
interface stream_if #(parameter int W = 18);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : stream_if

/* File: logic/word_fifo.sv */
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH of at least two; synchronous active-low reset.
// Notes:   Full and empty come straight from the occupancy count.
`timescale 1ns/1ns
module word_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Filling side and draining side
    stream_if.sink   in_s,
    stream_if.source out_s
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] used;
    logic          push;
    logic          pop;

    assign in_s.ready  = (used != CW'(DEPTH));
    assign out_s.valid = (used != '0);
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                used <= used + 1'b1;
            end else if (pop && !push) begin
                used <= used - 1'b1;
            end
        end
    end
endmodule : word_fifo

/* File: tb/bus_partner.sv */
// Purpose: Far-side bus logic on the A and B buses.
// Assumes: The wire carries the device's value wherever its enable is high.
// Notes:   Bits nobody drives toggle every cycle so a stale value never passes.
`timescale 1ns/1ns
module bus_partner
    import bus_xcvr_pkg::*;
(
    // Clock
    input  wire logic             CLK,
    // Far-side drive requests
    input  wire logic [BUS_W-1:0] a_val,
    input  wire logic [BUS_W-1:0] a_en,
    input  wire logic [BUS_W-1:0] b_val,
    input  wire logic [BUS_W-1:0] b_en,
    // Device pins
    input  wire logic [BUS_W-1:0] A_OUT,
    input  wire logic [BUS_W-1:0] A_OE,
    input  wire logic [BUS_W-1:0] B_OUT,
    input  wire logic [BUS_W-1:0] B_OE,
    output logic      [BUS_W-1:0] A_IN,
    output logic      [BUS_W-1:0] B_IN
);
    logic [BUS_W-1:0] flip = '0;
    always_ff @(posedge CLK) begin
        flip <= ~flip;
    end
    // The far side yields wherever the device drives.
    assign A_IN = (A_OE & A_OUT) | (~A_OE & a_en & a_val) | (~A_OE & ~a_en & flip);
    assign B_IN = (B_OE & B_OUT) | (~B_OE & b_en & b_val) | (~B_OE & ~b_en & flip);
endmodule : bus_partner

/* File: tb/test_registered_bus_transceiver_scan.sv */
// Purpose: Self-checking bench for the scan-testable bus transceiver.
// Assumes: TCK high for four CLK cycles and low for at least eight; inputs change 1 ns after a CLK rise.
// Notes:   Expected values are worked out here from the pin behaviour.
`timescale 1ns/1ns
module test_registered_bus_transceiver_scan;
    import bus_xcvr_pkg::*;
    localparam int LIMIT = 10000;
    logic              clk = 0, rst_n = 0, tck = 0, tms = 1, tdi = 1, tdo, tdo_oe;
    logic [BUS_W-1:0]  a_out, a_oe, b_out, b_oe, a_in, b_in;
    logic [BUS_W-1:0]  a_val = '0, b_val = '0, a_en = '1, b_en = '1;
    logic [HALVES-1:0] ab_oe_n = '1, ba_oe_n = '1, ab_le = '0, ba_le = '0, ab_clk = '0, ba_clk = '0;
    int                n_mismatch = 0, n_checks = 0, cycles = 0;

    always #5 clk = ~clk;

    registered_bus_transceiver_scan i_registered_bus_transceiver_scan (
        .CLK(clk), .RST_N(rst_n), .A_IN(a_in), .A_OUT(a_out), .A_OE(a_oe),
        .B_IN(b_in), .B_OUT(b_out), .B_OE(b_oe),
        .A_TO_B_OUTPUT_ENABLE_N(ab_oe_n), .B_TO_A_OUTPUT_ENABLE_N(ba_oe_n),
        .A_TO_B_LATCH_ENABLE(ab_le), .B_TO_A_LATCH_ENABLE(ba_le),
        .A_TO_B_CLOCK(ab_clk), .B_TO_A_CLOCK(ba_clk),
        .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));

    bus_partner i_bus_partner (
        .CLK(clk), .a_val(a_val), .a_en(a_en), .b_val(b_val), .b_en(b_en),
        .A_OUT(a_out), .A_OE(a_oe), .B_OUT(b_out), .B_OE(b_oe), .A_IN(a_in), .B_IN(b_in));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One TCK period; TDO is taken once the falling edge has settled.
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        step(4);
        tck = 1;
        step(4);
        tck = 0;
        step(4);
        q = tdo;
    endtask : tick

    task automatic scan(input bit ir, input int n, input logic [39:0] din, output logic [39:0] dout);
        logic q;
        dout = '0;
        tick(1, 1, q);
        if (ir) tick(1, 1, q);
        tick(0, 1, q);
        tick(0, 1, q);
        check("tdo_oe shifting", 64'h1, 64'(tdo_oe));
        for (int i = 0; i < n; i++) begin
            dout[i] = q;
            tick(i == n - 1, din[i], q);
        end
        tick(1, 1, q);
        tick(0, 1, q);
    endtask : scan

    task automatic t_paths();
        a_val = 18'h2B5A7;
        ab_le = 2'h1;
        ab_oe_n = 2'h2;
        step(5);
        check("b_out half0", 64'(a_val[8:0]), 64'(b_out[8:0]));
        check("b_oe half0 only", 64'h001FF, 64'(b_oe));
        ab_oe_n = 2'h0;
        ab_le = 2'h3;
        step(5);
        check("b_out full", 64'(a_val), 64'(b_out));
        ab_le = 2'h0;
        step(3);
        a_val = 18'h1C3E4;
        step(6);
        check("b_out held", 64'h2B5A7, 64'(b_out));
        ab_clk = 2'h3;
        step(6);
        check("b_out clocked", 64'h1C3E4, 64'(b_out));
        ab_clk = 2'h0;
        ab_oe_n = 2'h3;
        b_val = 18'h0F0F3;
        ba_le = 2'h3;
        ba_oe_n = 2'h0;
        step(6);
        check("a_out mirror", 64'(b_val), 64'(a_out));
        check("a_oe mirror", 64'h3FFFF, 64'(a_oe));
        ba_oe_n = 2'h3;
        step(4);
        check("a_oe off", 64'h0, 64'(a_oe));
        $display("t_paths done");
    endtask : t_paths

    task automatic t_sample();
        logic [39:0] d;
        logic        q;
        ab_oe_n = 2'h0;
        ab_le = 2'h3;
        // The port still rests in its reset state; one low TMS rise brings it to Idle.
        tick(0, 1, q);
        scan(1, IR_W, 40'(OP_SAMPLE), d);
        check("ir capture", 64'(IR_CAPTURE), 64'(d[7:0]));
        scan(0, BSR_W, '0, d);
        check("boundary capture", 64'({a_val, a_val}), 64'(d[35:0]));
        a_val = 18'h35A5A;
        step(5);
        check("b_out normal", 64'(a_val), 64'(b_out));
        $display("t_sample done");
    endtask : t_sample

    task automatic t_extest();
        logic [39:0] d;
        logic        q;
        scan(1, IR_W, 40'(OP_EXTEST), d);
        scan(0, BSR_W, {4'h3, 18'h2A5C3, 18'h00000}, d);
        step(3);
        check("b_out forced", 64'h2A5C3, 64'(b_out));
        check("b_oe forced", 64'h3FFFF, 64'(b_oe));
        check("a_oe forced", 64'h0, 64'(a_oe));
        repeat (5) tick(1, 1, q);
        step(5);
        check("b_out released", 64'(a_val), 64'(b_out));
        tick(0, 1, q);
        $display("t_extest done");
    endtask : t_extest

    task automatic t_count();
        logic [39:0]      d;
        logic [BUS_W-1:0] e;
        logic             q;
        scan(1, IR_W, 40'(OP_EXTEST), d);
        scan(0, BSR_W, {4'h3, 36'h0}, d);
        scan(1, IR_W, 40'(OP_COUNT), d);
        repeat (6) tick(0, 1, q);
        check("count on b", 64'h6, 64'(b_out));
        scan(0, BUS_W, '0, d);
        // The scan's first rise still falls in Idle, so a seventh word is compressed.
        e = '0;
        repeat (7) e = {e[16:0], e[17] ^ e[10]} ^ a_val;
        check("signature", 64'(e), 64'(d[17:0]));
        scan(1, IR_W, 40'(OP_PSEUDO_RANDOM_PATTERN_GEN), d);
        repeat (5) tick(0, 1, q);
        e = PSEUDO_RANDOM_PATTERN_GEN_SEED;
        repeat (5) e = {e[16:0], e[17] ^ e[10]};
        check("pattern on b", 64'(e), 64'(b_out));
        repeat (5) tick(1, 1, q);
        $display("t_count done");
    endtask : t_count

    task automatic t_psa();
        logic [39:0]      d;
        logic [BUS_W-1:0] e;
        logic             q;
        tick(0, 1, q);
        scan(1, IR_W, 40'(OP_PSA), d);
        repeat (3) tick(0, 1, q);
        check("b_oe in psa", 64'h0, 64'(b_oe));
        scan(0, BUS_W, '0, d);
        // Three idle rises plus the first rise of the scan give four words.
        e = '0;
        repeat (4) e = {e[16:0], e[17] ^ e[10]} ^ a_val;
        check("psa signature", 64'(e), 64'(d[17:0]));
        repeat (5) tick(1, 1, q);
        $display("t_psa done");
    endtask : t_psa

    initial begin
        step(20);
        rst_n = 1;
        step(1);
        check("b_oe after reset", 64'h0, 64'(b_oe));
        check("tdo_oe after reset", 64'h0, 64'(tdo_oe));
        $display("t_reset done");
        t_paths();
        t_sample();
        t_extest();
        t_count();
        t_psa();
        wrap_up();
    end
endmodule : test_registered_bus_transceiver_scan
